/* rtl/pll_div_core.sv */
// serial dual-modulus pll divider core
`timescale 1ns/1ps
`default_nettype none
module pll_div_core (
    // clock and reset
    input  wire logic clk_in,
    input  wire logic reset_in,
    // serial link
    input  wire logic shift_clk_in,
    input  wire logic shift_data_in,
    input  wire logic latch_strobe_in,
    // frequency inputs
    input  wire logic ref_osc_in,
    input  wire logic vco_freq_in,
    // outputs
    output logic      ref_osc_drive_out,
    output logic      ref_osc_buffered_out,
    output logic      modulus_select_out,
    output logic      ref_divided_out,
    output logic      vco_divided_out,
    output logic      phase_ref_out,
    output logic      phase_vco_out,
    output logic      tristate_error_out,
    output logic      tristate_error_oe_out,
    output logic      lock_indicator_out
);
    localparam int RW = pll_div_pkg::REF_W;
    localparam int MW = pll_div_pkg::MAIN_W;
    localparam int SW = pll_div_pkg::SWAL_W;
    localparam int TW = pll_div_pkg::SR_W;
    localparam int PC = pll_div_pkg::PULSE_CYC;

    // ************************************************
    // input synchronisers
    // ************************************************
    logic [4:0] sync1_ff;
    logic [4:0] sync2_ff;
    logic [4:0] prev_ff;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            sync1_ff <= 5'h00;
            sync2_ff <= 5'h00;
            prev_ff  <= 5'h00;
        end else begin
            sync1_ff <= {latch_strobe_in, shift_data_in, shift_clk_in, ref_osc_in, vco_freq_in};
            sync2_ff <= sync1_ff;
            prev_ff  <= sync2_ff;
        end
    end
    logic vco_rise;
    logic ref_rise;
    logic sck_rise;
    logic sdat;
    logic strobe;
    assign vco_rise = sync2_ff[0] & ~prev_ff[0];
    assign ref_rise = sync2_ff[1] & ~prev_ff[1];
    assign sck_rise = sync2_ff[2] & ~prev_ff[2];
    assign sdat     = sync2_ff[3];
    assign strobe   = sync2_ff[4];

    // ************************************************
    // shift register and latches
    // ************************************************
    logic [TW-1:0] shift_ff;
    logic [RW-1:0] ref_lat_ff;
    logic [MW-1:0] main_lat_ff;
    logic [SW-1:0] swal_lat_ff;
    logic          ctrl_bit;
    assign ctrl_bit = shift_ff[pll_div_pkg::CTRL_POS];
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            shift_ff <= '0;
        end else if (sck_rise) begin
            shift_ff <= {shift_ff[TW-2:0], sdat};
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ref_lat_ff  <= pll_div_pkg::REF_RST;
            main_lat_ff <= pll_div_pkg::MAIN_RST;
            swal_lat_ff <= pll_div_pkg::SWAL_RST;
        end else if (strobe) begin
            if (ctrl_bit) begin
                ref_lat_ff <= shift_ff[RW:1];
            end else begin
                main_lat_ff <= shift_ff[MW+SW:SW+1];
                swal_lat_ff <= shift_ff[SW:1];
            end
        end
    end

    // ************************************************
    // reference divider
    // ************************************************
    logic [RW-1:0] ref_cnt_ff;
    logic          ref_pulse_ff;
    logic [RW-1:0] ref_eff;
    assign ref_eff = (ref_lat_ff < pll_div_pkg::REF_MIN) ? pll_div_pkg::REF_MIN : ref_lat_ff;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            ref_cnt_ff   <= pll_div_pkg::REF_RST;
            ref_pulse_ff <= 1'b0;
        end else begin
            ref_pulse_ff <= 1'b0;
            if (ref_rise) begin
                if (ref_cnt_ff <= RW'(1)) begin
                    ref_cnt_ff   <= ref_eff;
                    ref_pulse_ff <= 1'b1;
                end else begin
                    ref_cnt_ff <= ref_cnt_ff - RW'(1);
                end
            end
        end
    end

    // ************************************************
    // main and swallow counters
    // ************************************************
    typedef enum logic [1:0] {
        SWALLOW = 2'b01,
        REST    = 2'b10
    } mod_state_t;
    mod_state_t    state_ff;
    logic [MW-1:0] main_cnt_ff;
    logic [SW-1:0] swal_cnt_ff;
    logic          vco_pulse_ff;
    logic [MW-1:0] main_eff;
    assign main_eff = (main_lat_ff < pll_div_pkg::MAIN_MIN) ? pll_div_pkg::MAIN_MIN : main_lat_ff;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            main_cnt_ff  <= pll_div_pkg::MAIN_RST;
            swal_cnt_ff  <= pll_div_pkg::SWAL_RST;
            state_ff     <= SWALLOW;
            vco_pulse_ff <= 1'b0;
        end else begin
            vco_pulse_ff <= 1'b0;
            if (vco_rise) begin
                if (main_cnt_ff <= MW'(1)) begin
                    main_cnt_ff  <= main_eff;
                    swal_cnt_ff  <= swal_lat_ff;
                    state_ff     <= SWALLOW;
                    vco_pulse_ff <= 1'b1;
                end else begin
                    main_cnt_ff <= main_cnt_ff - MW'(1);
                    case (state_ff)
                        SWALLOW: begin
                            if (swal_cnt_ff <= SW'(1)) begin
                                swal_cnt_ff <= '0;
                                state_ff    <= REST;
                            end else begin
                                swal_cnt_ff <= swal_cnt_ff - SW'(1);
                            end
                        end
                        REST: begin
                            state_ff <= REST;
                        end
                        default: begin
                            state_ff <= SWALLOW;
                        end
                    endcase
                end
            end else if (state_ff == SWALLOW && swal_cnt_ff == '0) begin
                // zero swallow: straight to high level
                state_ff <= REST;
            end
        end
    end
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            modulus_select_out <= 1'b0;
        end else begin
            modulus_select_out <= (state_ff == REST);
        end
    end

    // ************************************************
    // phase frequency detector
    // ************************************************
    logic up_ff;
    logic dn_ff;
    logic [3:0] hold_ff;
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            up_ff   <= 1'b0;
            dn_ff   <= 1'b0;
            hold_ff <= '0;
        end else if (hold_ff != '0) begin
            hold_ff <= hold_ff - 4'h1;
            if (hold_ff == 4'h1) begin
                up_ff <= ref_pulse_ff;
                dn_ff <= vco_pulse_ff;
            end else begin
                up_ff <= up_ff | ref_pulse_ff;
                dn_ff <= dn_ff | vco_pulse_ff;
            end
        end else if ((up_ff | ref_pulse_ff) & (dn_ff | vco_pulse_ff)) begin
            up_ff   <= 1'b1;
            dn_ff   <= 1'b1;
            hold_ff <= 4'(PC);
        end else begin
            up_ff <= up_ff | ref_pulse_ff;
            dn_ff <= dn_ff | vco_pulse_ff;
        end
    end

    // ************************************************
    // output registers
    // ************************************************
    always_ff @(posedge clk_in) begin
        if (reset_in) begin
            phase_ref_out         <= 1'b1;
            phase_vco_out         <= 1'b1;
            tristate_error_out    <= 1'b0;
            tristate_error_oe_out <= 1'b0;
            lock_indicator_out    <= 1'b1;
            ref_divided_out       <= 1'b0;
            vco_divided_out       <= 1'b0;
            ref_osc_buffered_out  <= 1'b0;
            ref_osc_drive_out     <= 1'b1;
        end else begin
            phase_vco_out <= ~dn_ff;
            phase_ref_out <= ~up_ff;
            tristate_error_oe_out <= up_ff ^ dn_ff;
            tristate_error_out    <= up_ff & ~dn_ff;
            lock_indicator_out <= ~(up_ff ^ dn_ff);
            ref_divided_out      <= ref_pulse_ff;
            vco_divided_out      <= vco_pulse_ff;
            ref_osc_buffered_out <= sync2_ff[1];
            ref_osc_drive_out    <= ~sync2_ff[1];
        end
    end
endmodule
`default_nettype wire

/* rtl/pll_div_pkg.sv */
// constants for the serial dual-modulus pll divider core
// How it works
// - vco rising edge decrements main counter, swallow counter only until it expires
// - shift clock rising edge shifts data in
// - last bit: 1 reference, 0 counters
// - strobe high copies word into selected latch
// - strobe low leaves latches and counters alone
// - reference divider 3 to 16383, 14 bits
// - main counter accepts 3 to 1023
// - swallow counter accepts 0 to 127
// - modulus select low until swallow expires
// - modulus select high for remaining counts
// - main end: select low, counters reload
// - total divide is main times P plus swallow
// - error output low leading, high lagging, float
// - vco faster: vco side pulses low
// - vco slower: reference side pulses low
// - in lock both pulse low briefly together
// - divided outputs copy counter outputs
// - lock indicator high locked, pulses low otherwise
package pll_div_pkg;
    // ************************************************
    // field layout
    // ************************************************
    localparam int REF_W    = 14;
    localparam int MAIN_W   = 10;
    localparam int SWAL_W   = 7;
    localparam int SHIFT_W  = REF_W + 1;
    localparam int CNT_W    = MAIN_W + SWAL_W + 1;
    localparam int SR_W     = (SHIFT_W > CNT_W) ? SHIFT_W : CNT_W;
    localparam int CTRL_POS = 0;
    // ************************************************
    // reset values and minimum divide ratios
    // ************************************************
    localparam logic [REF_W-1:0]  REF_RST  = 14'h0008;
    localparam logic [MAIN_W-1:0] MAIN_RST = 10'h008;
    localparam logic [SWAL_W-1:0] SWAL_RST = 7'h00;
    localparam logic [REF_W-1:0]  REF_MIN  = 14'h0003;
    localparam logic [MAIN_W-1:0] MAIN_MIN = 10'h003;
    // ************************************************
    // timing
    // ************************************************
    localparam int PULSE_MIN_NS = 16;
    localparam int CLK_NS       = 8;
    localparam int PULSE_CYC    = (PULSE_MIN_NS + CLK_NS - 1) / CLK_NS;
endpackage

/* sim/pll_div_core_assertions.sv */
// concurrent checks on the divider core pins
`timescale 1ns/1ps
`default_nettype none
module pll_div_core_assertions (
    // clock and reset
    input wire logic clk_in,
    input wire logic reset_in,
    // watched pins
    input wire logic ref_osc_in,
    input wire logic vco_freq_in,
    input wire logic ref_osc_drive_out,
    input wire logic ref_osc_buffered_out,
    input wire logic modulus_select_out,
    input wire logic ref_divided_out,
    input wire logic vco_divided_out,
    input wire logic phase_ref_out,
    input wire logic phase_vco_out,
    input wire logic tristate_error_out,
    input wire logic tristate_error_oe_out,
    input wire logic lock_indicator_out
);
    logic [2:0] vco_age_ff;
    logic [2:0] ref_age_ff;
    default clocking @(posedge clk_in); endclocking
    default disable iff (reset_in);
    sequence both_high; phase_ref_out && phase_vco_out; endsequence
    sequence one_side; phase_ref_out ^ phase_vco_out; endsequence
    // cycles since each input rose
    always_ff @(posedge clk_in) begin
        vco_age_ff <= $rose(vco_freq_in) ? 3'h0 : (vco_age_ff == 3'h7) ? 3'h7 : vco_age_ff + 3'h1;
    end
    always_ff @(posedge clk_in) begin
        ref_age_ff <= $rose(ref_osc_in) ? 3'h0 : (ref_age_ff == 3'h7) ? 3'h7 : ref_age_ff + 3'h1;
    end
    reset_state_a: assert property (disable iff (1'b0) reset_in |=> phase_ref_out && phase_vco_out
        && lock_indicator_out && !modulus_select_out && !tristate_error_oe_out) else $error("bad reset state");
    sel_edge_a: assert property ($fell(modulus_select_out) |-> vco_age_ff < 3'h6)
        else $error("select fell off a vco edge");
    vdiv_edge_a: assert property (vco_divided_out |-> vco_age_ff < 3'h6) else $error("vco pulse off edge");
    rdiv_edge_a: assert property (ref_divided_out |-> ref_age_ff < 3'h6) else $error("ref pulse off edge");
    vdiv_pulse_a: assert property (vco_divided_out |=> !vco_divided_out) else $error("vco pulse too long");
    both_low_a: assert property (not ((!phase_ref_out && !phase_vco_out) [*5]))
        else $error("both detector sides low too long");
    err_sign_a: assert property (tristate_error_oe_out |-> tristate_error_out == phase_vco_out)
        else $error("error output sign wrong");
    err_float_a: assert property (both_high [*2] |-> !tristate_error_oe_out) else $error("error not floating");
    lock_low_a: assert property (one_side [*2] |-> !lock_indicator_out) else $error("lock high out of lock");
    lock_high_a: assert property (both_high [*3] |-> lock_indicator_out) else $error("lock low in lock");
    ref_copy_a: assert property (!$past(reset_in, 3) |-> ref_osc_buffered_out == $past(ref_osc_in, 3))
        else $error("buffered reference wrong");
    ref_drive_a: assert property (!$past(reset_in, 3) |-> ref_osc_drive_out == !$past(ref_osc_in, 3))
        else $error("reference drive wrong");
endmodule
bind pll_div_core pll_div_core_assertions u_check (.clk_in, .reset_in, .ref_osc_in, .vco_freq_in,
    .ref_osc_drive_out, .ref_osc_buffered_out, .modulus_select_out,
    .ref_divided_out, .vco_divided_out, .phase_ref_out, .phase_vco_out, .tristate_error_out, .tristate_error_oe_out,
    .lock_indicator_out);
`default_nettype wire

/* sim/pll_div_core_test.sv */
// self-checking bench for the divider core
`timescale 1ns/1ps
`default_nettype none
module pll_div_core_test;
    localparam int P = 4;
    logic        clk_in = 1'b0;
    logic        reset_in = 1'b1;
    logic        ref_osc_in = 1'b0;
    logic        shift_clk, shift_data, strobe, vco, sel, rdiv, vdiv;
    int          n_fail = 0;
    int          check_count = 0;
    int          ref_edges = 0;
    int          cycles = 0;
    int          snap;
    logic [31:0] lfsr = 32'h2BE5;
    logic [9:0]  n;
    logic [6:0]  a;
    logic [13:0] r;
    logic [9:0]  cn [3] = '{10'h003, 10'h003, 10'h3FF};
    logic [6:0]  ca [3] = '{7'h00, 7'h03, 7'h7F};
    pll_div_partner #(.P(P)) host (.shift_clk_out(shift_clk), .shift_data_out(shift_data),
        .latch_strobe_out(strobe), .modulus_select_in(sel), .vco_freq_out(vco));
    pll_div_core dut (.clk_in(clk_in), .reset_in(reset_in), .shift_clk_in(shift_clk), .shift_data_in(shift_data),
        .latch_strobe_in(strobe), .ref_osc_in(ref_osc_in), .vco_freq_in(vco), .ref_osc_drive_out(),
        .ref_osc_buffered_out(), .modulus_select_out(sel), .ref_divided_out(rdiv), .vco_divided_out(vdiv),
        .phase_ref_out(), .phase_vco_out(), .tristate_error_out(), .tristate_error_oe_out(),
        .lock_indicator_out());
    function automatic logic [31:0] next_rand(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction
    function automatic logic [31:0] exp_div(input int nv, input int av);
        return 32'(nv * P + av);
    endfunction
    function automatic logic [31:0] exp_ref(input int rv);
        return 32'((rv < 3) ? 3 : rv);
    endfunction
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic measure_vco(input logic [31:0] exp);
        @(posedge clk_in iff vdiv);
        snap = host.vco_cycles;
        @(posedge clk_in iff vdiv);
        check(32'(host.vco_cycles - snap), exp);
    endtask
    task automatic measure_ref(input logic [31:0] exp);
        @(posedge clk_in iff rdiv);
        snap = ref_edges;
        @(posedge clk_in iff rdiv);
        check(32'(ref_edges - snap), exp);
    endtask
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        forever #4 clk_in = ~clk_in;
    end
    initial begin
        forever begin
            repeat (6) @(posedge clk_in);
            #1 ref_osc_in = ~ref_osc_in;
            if (ref_osc_in) ref_edges++;
        end
    end
    always @(posedge clk_in) begin
        cycles++;
        if (cycles == 80000) begin
            n_fail++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (12) @(posedge clk_in);
        #1 reset_in = 1'b0;
        measure_ref(exp_ref(8));
        measure_vco(exp_div(8, 0));
        $display("test reset values done");
        for (int i = 0; i < 5; i++) begin
            lfsr = next_rand(lfsr);
            n = 10'h003 + 10'(lfsr[5:0]);
            a = 7'(lfsr[13:8] % (n + 10'h001));
            if (i < 3) begin
                n = cn[i];
                a = ca[i];
            end
            host.send({n, a, 1'b0}, 1'b1);
            measure_vco(exp_div(int'(n), int'(a)));
        end
        $display("test counter words done");
        host.send({10'h011, 7'h05, 1'b0}, 1'b0);
        measure_vco(exp_div(int'(n), int'(a)));
        $display("test strobe low done");
        for (int i = 0; i < 3; i++) begin
            lfsr = next_rand(lfsr);
            r = (i == 0) ? 14'h0003 : (i == 1) ? 14'h0002 : 14'h0004 + 14'(lfsr[4:0]);
            host.send({3'h0, r, 1'b1}, 1'b1);
            measure_ref(exp_ref(int'(r)));
        end
        measure_vco(exp_div(int'(n), int'(a)));
        $display("test reference words done");
        tally_and_finish();
    end
endmodule
`default_nettype wire

/* sim/pll_div_partner.sv */
// host serial port and dual-modulus prescaler model
`timescale 1ns/1ps
`default_nettype none
module pll_div_partner #(parameter int P = 4) (
    // serial link
    output var logic shift_clk_out,
    output var logic shift_data_out,
    output var logic latch_strobe_out,
    // prescaler
    input  wire logic modulus_select_in,
    output var logic vco_freq_out
);
    int vco_cycles = 0;
    int m;
    initial begin
        shift_clk_out = 1'b0;
        shift_data_out = 1'b0;
        latch_strobe_out = 1'b0;
        vco_freq_out = 1'b0;
        #3;
        forever begin
            // divide by P when high, P+1 when low
            // select is read once the core has answered the rising edge
            vco_freq_out = 1'b1;
            #40;
            m = modulus_select_in ? P : P + 1;
            vco_cycles += m;
            vco_freq_out = 1'b0;
            #(m * 20 - 40);
        end
    end
    task automatic send(input logic [17:0] word, input logic stb);
        for (int i = 17; i >= 0; i--) begin
            shift_data_out = word[i];
            #62.5 shift_clk_out = 1'b1;
            #62.5 shift_clk_out = 1'b0;
        end
        shift_data_out = ~word[0];
        // strobe low while shifting, one pulse after
        latch_strobe_out = stb;
        #100 latch_strobe_out = 1'b0;
        #100;
    endtask
endmodule
`default_nettype wire
